/* logic/cerf_regs.vh */
// Constants for the cluster error record feature and control registers.
// Assumes a 64-bit register port with byte offsets within the record block.
`ifndef CERF_REGS_VH
`define CERF_REGS_VH
`define CERF_BASE_ADDR        24'h020000
`define CERF_OFS_FEATURES     12'h000
`define CERF_OFS_CONTROL      12'h008
`define CERF_FEAT_TS_VAL      2'h0
`define CERF_FEAT_CI_VAL      2'h2
`define CERF_FEAT_INJ_VAL     2'h1
`define CERF_FEAT_CEO_VAL     2'h0
`define CERF_FEAT_DUI_VAL     2'h0
`define CERF_FEAT_RP_VAL      1'h1
`define CERF_FEAT_CEC_VAL     3'h2
`define CERF_FEAT_CFI_VAL     2'h2
`define CERF_FEAT_UE_VAL      2'h1
`define CERF_FEAT_FI_VAL      2'h2
`define CERF_FEAT_UI_VAL      2'h2
`define CERF_FEAT_DE_VAL      2'h1
`define CERF_FEAT_ED_VAL      2'h2
`define CERF_CTL_CRIT_BIT     13
`define CERF_CTL_LATER_BIT    10
`define CERF_CTL_CFI_BIT      8
`define CERF_CTL_FI_BIT       3
`define CERF_CTL_UI_BIT       2
`define CERF_CTL_ED_BIT       0
`define CERF_CNT_W            8
`endif

/* logic/cerf_record.v */
// Feature and control registers of a cluster error record, with the event
// gating and the repaired-error counters that those registers describe.
// Assumes one-cycle access strobes from the utility bus and the core
// system-register port, and error events synchronous to CLK.
//
// Functional notes
// - Timestamp field reads zero, writes ignored.
// - Critical interrupt field reads binary 10.
// - Fault insertion field reads binary 01.
// - Count repairs, keep first syndrome, overflow on wrap.
// - Later recovery field zero, its enable fixed.
// - Repeat and other counters, same width.
// - Counter field 010, eight-bit counter.
// - Repair fault field reads binary 10.
// - Inband abort field 01, always active.
// - Fault and recovery fields read 10.
// - Later error field reads 01.
// - Logging field reads binary 10.
// - Bit 13 gates critical interrupt.
// - Bit 10 reads zero, read only.
// - Bit 8 gates interrupt on counter wrap.
// - Bit 3 gates interrupt on repaired, later and uncorrected errors.
// - Bit 2 gates recovery on uncorrected error.
// - Interrupt raised even when syndrome dropped.
// - Bit 0 clear suppresses recording and signalling.
// - Reachable from utility bus and cores.
// - Unmapped or wrong security reads zero.
`timescale 1ns/1ps
`include "cerf_regs.vh"

module cerf_record (
  // Clock and reset
  input  wire        CLK,
  input  wire        RESET,
  // Utility bus register port
  input  wire        BUS_SEL,
  input  wire        BUS_WRITE,
  input  wire [23:0] BUS_ADDR,
  input  wire [63:0] BUS_WDATA,
  input  wire        BUS_SECURE_OK,
  output reg  [63:0] BUS_RDATA,
  output reg         BUS_RVALID,
  // Core system-register port
  input  wire        SYS_SEL,
  input  wire        SYS_WRITE,
  input  wire        SYS_REG,
  input  wire [63:0] SYS_WDATA,
  output reg  [63:0] SYS_RDATA,
  output reg         SYS_RVALID,
  // Error events
  input  wire        ERR_REPAIRED,
  input  wire        ERR_LATER,
  input  wire        ERR_UNCORR,
  input  wire        ERR_CRITICAL,
  input  wire [7:0]  ERR_SYNDROME,
  input  wire        ERR_SYN_DROPPED,
  input  wire        ERR_REPEAT,
  // Error outputs
  output reg         CRITICAL_IRQ,
  output reg         FAULT_IRQ,
  output reg         RECOVERY_IRQ,
  output reg         RECORD_VALID,
  output reg  [7:0]  RECORD_SYNDROME,
  output reg         RECORD_OVERFLOW_FLAG,
  output reg  [7:0]  REPAIR_COUNT,
  output reg  [7:0]  OTHER_COUNT
);

  wire [63:0] features;
  reg  [63:0] control;
  wire [63:0] control_view;
  wire        bus_hit;
  wire        bus_ctl;
  wire        bus_feat;
  wire        sys_ctl;
  wire        log_on;
  wire        rep_ev;
  wire        rep_wrap;
  wire        oth_wrap;
  wire        new_err;
  wire [8:0]  next_rep;
  wire [8:0]  next_oth;
  wire [23:0] base_addr;

  // The block base is compared on its upper twelve bits only.
  assign base_addr = `CERF_BASE_ADDR;

  assign features = {38'h0,
                     `CERF_FEAT_TS_VAL,
                     `CERF_FEAT_CI_VAL,
                     `CERF_FEAT_INJ_VAL,
                     `CERF_FEAT_CEO_VAL,
                     `CERF_FEAT_DUI_VAL,
                     `CERF_FEAT_RP_VAL,
                     `CERF_FEAT_CEC_VAL,
                     `CERF_FEAT_CFI_VAL,
                     `CERF_FEAT_UE_VAL,
                     `CERF_FEAT_FI_VAL,
                     `CERF_FEAT_UI_VAL,
                     `CERF_FEAT_DE_VAL,
                     `CERF_FEAT_ED_VAL};

  // Only the implemented enables are visible; the rest read zero.
  assign control_view = control & 64'h0000_0000_0000_210D;

  // Address decode on the utility bus; security failures read as unmapped.
  assign bus_hit  = BUS_SEL && BUS_SECURE_OK &&
                    (BUS_ADDR[23:12] == base_addr[23:12]);
  assign bus_feat = bus_hit && (BUS_ADDR[11:0] == `CERF_OFS_FEATURES);
  assign bus_ctl  = bus_hit && (BUS_ADDR[11:0] == `CERF_OFS_CONTROL);
  assign sys_ctl  = SYS_SEL && SYS_REG;

  always @(posedge CLK) begin
    if (RESET) begin
      BUS_RDATA  <= 64'h0;
      BUS_RVALID <= 1'b0;
      SYS_RDATA  <= 64'h0;
      SYS_RVALID <= 1'b0;
    end else begin
      BUS_RVALID <= BUS_SEL && !BUS_WRITE;
      SYS_RVALID <= SYS_SEL && !SYS_WRITE;
      BUS_RDATA  <= 64'h0;
      SYS_RDATA  <= 64'h0;
      if (BUS_SEL && !BUS_WRITE && bus_feat) begin
        BUS_RDATA <= features;
      end else if (BUS_SEL && !BUS_WRITE && bus_ctl) begin
        BUS_RDATA <= control_view;
      end
      if (SYS_SEL && !SYS_WRITE) begin
        SYS_RDATA <= SYS_REG ? control_view : features;
      end
    end
  end

  // Enables have no reset value; they keep the last write from either port.
  // The bus write wins when both ports write in the same cycle.
  always @(posedge CLK) begin
    if (BUS_WRITE && bus_ctl) begin
      control <= BUS_WDATA;
    end else if (SYS_WRITE && sys_ctl) begin
      control <= SYS_WDATA;
    end
  end

  assign log_on   = control_view[`CERF_CTL_ED_BIT];
  assign rep_ev   = log_on && ERR_REPAIRED;
  assign next_rep = {1'b0, REPAIR_COUNT} + 9'h001;
  assign next_oth = {1'b0, OTHER_COUNT} + 9'h001;
  assign rep_wrap = rep_ev && ERR_REPEAT && next_rep[8];
  assign oth_wrap = rep_ev && !ERR_REPEAT && next_oth[8];
  assign new_err  = log_on && (ERR_REPAIRED || ERR_LATER || ERR_UNCORR);

  // Counters start from zero so that a wrap is well defined after reset.
  always @(posedge CLK) begin
    if (RESET) begin
      REPAIR_COUNT         <= 8'h00;
      OTHER_COUNT          <= 8'h00;
      RECORD_VALID         <= 1'b0;
      RECORD_SYNDROME      <= 8'h00;
      RECORD_OVERFLOW_FLAG <= 1'b0;
    end else begin
      if (rep_ev && ERR_REPEAT) begin
        REPAIR_COUNT <= next_rep[7:0];
      end
      if (rep_ev && !ERR_REPEAT) begin
        OTHER_COUNT <= next_oth[7:0];
      end
      if (new_err && !RECORD_VALID) begin
        RECORD_VALID    <= 1'b1;
        RECORD_SYNDROME <= ERR_SYNDROME;
      end
      if (rep_wrap || oth_wrap) begin
        RECORD_OVERFLOW_FLAG <= 1'b1;
      end
    end
  end

  // Interrupts are pulses per event and ignore ERR_SYN_DROPPED on purpose.
  always @(posedge CLK) begin
    if (RESET) begin
      CRITICAL_IRQ <= 1'b0;
      FAULT_IRQ    <= 1'b0;
      RECOVERY_IRQ <= 1'b0;
    end else begin
      CRITICAL_IRQ <= log_on && ERR_CRITICAL &&
                      control_view[`CERF_CTL_CRIT_BIT];
      FAULT_IRQ    <= (new_err && control_view[`CERF_CTL_FI_BIT]) ||
                      ((rep_wrap || oth_wrap) &&
                       control_view[`CERF_CTL_CFI_BIT]);
      RECOVERY_IRQ <= log_on && ERR_UNCORR && !ERR_LATER &&
                      control_view[`CERF_CTL_UI_BIT];
    end
  end

endmodule // cerf_record

/* tb/cerf_record_properties.sv */
// Concurrent checks on the ports of the cluster error record block.
// Assumes one CLK domain with synchronous active-high RESET; bound by name from the bench.
`timescale 1ns/1ps
module cerf_record_properties (
  input wire        CLK, RESET, BUS_SEL, BUS_WRITE, BUS_SECURE_OK, BUS_RVALID,
  input wire [23:0] BUS_ADDR,
  input wire [63:0] BUS_WDATA, BUS_RDATA, SYS_WDATA, SYS_RDATA,
  input wire        SYS_SEL, SYS_WRITE, SYS_REG, ERR_REPAIRED, ERR_LATER, ERR_UNCORR,
  input wire        ERR_CRITICAL, ERR_REPEAT, CRITICAL_IRQ, FAULT_IRQ, RECOVERY_IRQ,
  input wire        RECORD_OVERFLOW_FLAG,
  input wire [7:0]  REPAIR_COUNT
);
  // Shadow of the control word; it stays unknown until software writes it, like the real one.
  reg  [63:0] ctl;
  wire        bus_rd = BUS_SEL && !BUS_WRITE;
  wire        sec_f  = BUS_SECURE_OK && BUS_ADDR == 24'h020000;
  wire        sec_c  = BUS_SECURE_OK && BUS_ADDR == 24'h020008;
  always @(posedge CLK)
    if (BUS_SEL && BUS_WRITE && sec_c) ctl <= BUS_WDATA;
    else if (SYS_SEL && SYS_WRITE && SYS_REG) ctl <= SYS_WDATA;
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_feat; bus_rd && sec_f |=> BUS_RVALID && BUS_RDATA == 64'h90A9A6; endproperty
  a_feat: assert property (p_feat) else $error("feature read wrong");
  property p_sysf; SYS_SEL && !SYS_WRITE && !SYS_REG |=> SYS_RDATA == 64'h90A9A6; endproperty
  a_sysf: assert property (p_sysf) else $error("core feature read wrong");
  property p_ctl; SYS_SEL && !SYS_WRITE && SYS_REG |=> SYS_RDATA == ($past(ctl) & 64'h210D);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control read wrong");
  property p_raz; bus_rd && !sec_f && !sec_c |=> BUS_RDATA == 64'h0; endproperty
  a_raz: assert property (p_raz) else $error("unmapped read not zero");
  property p_crit; ERR_CRITICAL && ctl[13] && ctl[0] |=> CRITICAL_IRQ; endproperty
  a_crit: assert property (p_crit) else $error("critical irq missing");
  property p_fault; (ERR_REPAIRED || ERR_LATER || ERR_UNCORR) && ctl[3] && ctl[0] |=> FAULT_IRQ;
  endproperty
  a_fault: assert property (p_fault) else $error("fault irq missing");
  property p_rec; ERR_UNCORR && !ERR_LATER && ctl[2] && ctl[0] |=> RECOVERY_IRQ; endproperty
  a_rec: assert property (p_rec) else $error("recovery irq missing");
  property p_off; !ctl[0] |=> !CRITICAL_IRQ && !FAULT_IRQ && !RECOVERY_IRQ; endproperty
  a_off: assert property (p_off) else $error("irq while logging off");
  property p_wrap; ERR_REPAIRED && ERR_REPEAT && ctl[0] && REPAIR_COUNT == 8'hFF |=>
    REPAIR_COUNT == 8'h00 && RECORD_OVERFLOW_FLAG && (FAULT_IRQ || !$past(ctl[8])); endproperty
  a_wrap: assert property (p_wrap) else $error("counter wrap wrong");
endmodule // cerf_record_properties

/* tb/cerf_record_test.sv */
// Self-checking bench for the cluster error record feature and control registers.
// Assumes the checker file is compiled first; drives both register ports and the events.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
  $display("ERROR %0t: got %h want %h", $time, a, b); end end
module cerf_record_test;
  reg         CLK, RESET, BUS_SEL, BUS_WRITE, BUS_SECURE_OK, SYS_SEL, SYS_WRITE, SYS_REG;
  reg  [23:0] BUS_ADDR;
  reg  [63:0] BUS_WDATA, SYS_WDATA, c, r, d;
  reg  [7:0]  ERR_SYNDROME, rc, oc, rs;
  reg         rv;
  reg         ERR_REPAIRED, ERR_LATER, ERR_UNCORR, ERR_CRITICAL, ERR_SYN_DROPPED, ERR_REPEAT;
  wire [63:0] BUS_RDATA, SYS_RDATA;
  wire [7:0]  RECORD_SYNDROME, REPAIR_COUNT, OTHER_COUNT;
  wire        BUS_RVALID, SYS_RVALID, CRITICAL_IRQ, FAULT_IRQ, RECOVERY_IRQ, RECORD_VALID;
  wire        RECORD_OVERFLOW_FLAG;
  integer     fails = 0, checks = 0, i;
  cerf_record dut (.*);
  initial begin
    CLK = 0;
    forever #2 CLK = ~CLK;
  end
  // One access on either port; an idle cycle follows so the strobe never toggles twice at once.
  task acc(input p, input w, input [23:0] a, input [63:0] dd);
    if (p) {BUS_SEL, BUS_WRITE, BUS_ADDR, BUS_WDATA} = {1'b1, w, a, dd};
    else {SYS_SEL, SYS_WRITE, SYS_REG, SYS_WDATA} = {1'b1, w, a[3], dd};
    @(posedge CLK); #1 r = p ? BUS_RDATA : SYS_RDATA;
    if (!w) `CHK(p ? BUS_RVALID : SYS_RVALID, 1'b1)
    {BUS_SEL, SYS_SEL} = 2'h0;
    @(posedge CLK); #1;
  endtask
  // Event bits are repaired, later, uncorrected, critical, repeat.
  task hit(input [4:0] e);
    reg [2:0] x;
    reg       wr;
    wr = c[0] & e[4] & ((e[0] ? rc : oc) == 8'hFF);
    x = {c[0] & c[13] & e[1], c[0] & (c[3] & (|e[4:2]) | c[8] & wr), c[0] & c[2] & e[2] & !e[3]};
    {ERR_REPAIRED, ERR_LATER, ERR_UNCORR, ERR_CRITICAL, ERR_REPEAT} = e;
    ERR_SYNDROME = $urandom;
    if (!rv && c[0] && (|e[4:2])) begin
      rv = 1'b1;
      rs = ERR_SYNDROME;
    end
    ERR_SYN_DROPPED = $urandom;
    @(posedge CLK); #1 `CHK({CRITICAL_IRQ, FAULT_IRQ, RECOVERY_IRQ}, x)
    if (c[0] & e[4]) if (e[0]) rc++; else oc++;
    `CHK({REPAIR_COUNT, OTHER_COUNT}, {rc, oc})
    `CHK({RECORD_VALID, RECORD_SYNDROME}, {rv, rs})
    {ERR_REPAIRED, ERR_LATER, ERR_UNCORR, ERR_CRITICAL} = 4'h0;
    @(posedge CLK); #1;
  endtask
  task final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #20000 fails++;
    final_report;
  end
  initial begin
    {RESET, BUS_SEL, BUS_WRITE, BUS_SECURE_OK, SYS_SEL, SYS_WRITE, SYS_REG} = 7'h40;
    {BUS_ADDR, BUS_WDATA, SYS_WDATA, ERR_SYNDROME, rc, oc, rs, rv} = 0;
    {ERR_REPAIRED, ERR_LATER, ERR_UNCORR, ERR_CRITICAL, ERR_SYN_DROPPED, ERR_REPEAT} = 6'h00;
    i = $urandom(10);
    repeat (20) @(posedge CLK);
    #1 {RESET, BUS_SECURE_OK} = 2'h1;
    for (i = 0; i < 4; i++) begin
      acc(i[0], 1, 24'h020000, {$urandom, $urandom});
      acc(i[1], 0, 24'h020000, 0); `CHK(r, 64'h90A9A6)
    end
    $display("test features done");
    for (i = 0; i < 8; i++) begin
      c = {$urandom, $urandom};
      acc(i[0], 1, 24'h020008, c);
      acc(!i[0], 0, 24'h020008, 0); `CHK(r, c & 64'h210D)
    end
    $display("test control done");
    BUS_SECURE_OK = 0;
    acc(1, 1, 24'h020008, ~c);
    acc(1, 0, 24'h020008, 0); `CHK(r, 64'h0)
    BUS_SECURE_OK = 1;
    acc(1, 1, 24'h020010, ~c);
    acc(1, 0, 24'h020010, 0); `CHK(r, 64'h0)
    acc(0, 0, 24'h020008, 0); `CHK(r, c & 64'h210D)
    $display("test refused access done");
    for (i = 0; i < 64; i++) begin
      if (i % 8 == 0) begin
        c = {$urandom, $urandom};
        acc(1, 1, 24'h020008, c);
      end
      d = $urandom;
      d[2] = d[2] | d[1];
      hit(d[4:0]);
    end
    $display("test events done");
    c = 64'h101;
    acc(0, 1, 24'h020008, c);
    repeat (256) hit(5'h11);
    `CHK(RECORD_OVERFLOW_FLAG, 1'b1)
    $display("test counter wrap done");
    final_report;
  end
endmodule // cerf_record_test
bind cerf_record cerf_record_properties chk (.*);
